// File: rtl/core_regs.sv
// Change guard, stack pointer and status flag registers of the CPU core.
// What this block does
// - Self-program key opens a window for the self-program instruction within four instructions.
// - Self-program window closes at once on flash, controller or EEPROM access, or sleep.
// - No interrupt is serviced while a guard window is open; requests stay pending.
// - When the window ends, pending interrupts are dispatched again.
// - I/O unlock key lets protected registers change during the next four instructions.
// - Guard bit 0 reads one while an I/O unlock window is open.
// - Guard bit 1 reads one while a self-program window is open.
// - Guard bits seven to two always read zero.
// - Reset loads the stack pointer with the top SRAM address.
// - Only needed stack pointer bits exist; others read zero.
// - Stack pointer low byte at base offset, high byte at base plus one.
// - Low byte write blocks interrupts four instructions or until next I/O write.
// - Status bit 7 is the global interrupt enable gating all interrupts.
// - Taking an interrupt leaves the global enable unchanged.
// - Changing the global enable by an I/O access costs one wait state.
// - Status bit 6 is the bit-copy store for bit store and bit load.
// - Sign bit always equals negative xor overflow.
// - Half carry, overflow, negative, zero and carry take the latest ALU result where its flag mask bit is set.
// - I/O unlock window closes on I/O or data write, memory access, or sleep.
`timescale 1ns/10ps
`default_nettype none
`include "core_regs_regs.svh"
module core_regs #(
  parameter int           SP_BITS  = 16,
  parameter logic [15:0]  SRAM_TOP = 16'hffff
) (
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        CE,
  input  wire logic [5:0]  IO_ADDR,
  input  wire logic        IO_WR,
  input  wire logic        IO_RD,
  input  wire logic [7:0]  IO_WDATA,
  output logic      [7:0]  IO_RDATA,
  output logic             IO_WAIT,
  input  wire logic        DATA_WR,
  input  wire logic        NVM_ACCESS,
  input  wire logic        SLEEP_EXEC,
  input  wire logic        INSTR_RETIRE,
  input  wire logic        INT_TAKEN,
  input  wire logic        SEI_EXEC,
  input  wire logic        CLI_EXEC,
  input  wire logic        BIT_STORE_INSTR,
  input  wire logic        BIT_STORE_VAL,
  input  wire logic        ALU_UPDATE,
  input  wire logic [4:0]  ALU_FLAGS,
  input  wire logic [4:0]  ALU_FLAG_MASK,
  input  wire logic        SP_LOAD,
  input  wire logic [15:0] SP_NEXT,
  input  wire logic        INT_PENDING,
  output logic             INT_ALLOW,
  output logic             IO_UNLOCKED,
  output logic             SELF_PROG_OK,
  output logic             BIT_LOAD_VAL,
  output logic [15:0]      STACK_POINTER,
  output logic [7:0]       STATUS_FLAGS
);
  logic [7:0]  status_flags_r;
  logic [15:0] sp_r;
  logic [7:0]  sp_temp_r;
  logic [7:0]  sp_rd_temp_r;
  logic [7:0]  status_nxt;
  logic [15:0] sp_mask;
  logic        io_win;
  logic        sp_win;
  logic        sp_block;
  logic        wait_r;
  logic        wr_guard;
  logic        key_io;
  logic        key_sp;
  logic        wr_spl;
  logic        wr_sph;
  logic        wr_status;
  logic        io_write_other;
  logic        ie_change;
  core_regs_pkg::window_e win_kind;

  if (SP_BITS < 1 || SP_BITS > 16) begin : g_bad_sp_bits
    $error("SP_BITS out of range.");
  end

  assign sp_mask        = 16'((17'h1 << SP_BITS) - 17'h1);
  assign wr_guard       = IO_WR && IO_ADDR == `GUARD_OFF;
  assign key_io         = wr_guard && IO_WDATA == `IO_UNLOCK_KEY;
  assign key_sp         = wr_guard && IO_WDATA == `SELF_PROGRAM_KEY;
  assign wr_spl         = IO_WR && IO_ADDR == `SP_LOW_OFF;
  assign wr_sph         = IO_WR && IO_ADDR == `SP_HIGH_OFF;
  assign wr_status      = IO_WR && IO_ADDR == `STATUS_OFF;
  assign io_write_other = IO_WR && !key_io;
  assign ie_change      = wr_status && IO_WDATA[`ST_IE_BIT] != status_flags_r[`ST_IE_BIT];
  assign win_kind       = io_win ? core_regs_pkg::WIN_IO
                        : (sp_win ? core_regs_pkg::WIN_SELFPROG : core_regs_pkg::WIN_NONE);

  instr_window #(.LENGTH(`WINDOW_INSTRS)) u_io_win (
    .CLK    (CLK),
    .NRST   (NRST),
    .CE     (CE),
    .start  (key_io),
    .retire (INSTR_RETIRE),
    .abort  (io_write_other || DATA_WR || NVM_ACCESS || SLEEP_EXEC),
    .open_o (io_win)
  );

  instr_window #(.LENGTH(`WINDOW_INSTRS)) u_sp_win (
    .CLK    (CLK),
    .NRST   (NRST),
    .CE     (CE),
    .start  (key_sp),
    .retire (INSTR_RETIRE),
    .abort  (NVM_ACCESS || SLEEP_EXEC),
    .open_o (sp_win)
  );

  instr_window #(.LENGTH(`WINDOW_INSTRS)) u_sp_block (
    .CLK    (CLK),
    .NRST   (NRST),
    .CE     (CE),
    .start  (wr_spl),
    .retire (INSTR_RETIRE),
    .abort  (IO_WR),
    .open_o (sp_block)
  );

  // Status register next value from software, instructions and the ALU.
  always_comb begin
    status_nxt = status_flags_r;
    if (wr_status) begin
      status_nxt = IO_WDATA;
    end else begin
      if (SEI_EXEC) status_nxt[`ST_IE_BIT] = 1'b1;
      if (CLI_EXEC) status_nxt[`ST_IE_BIT] = 1'b0;
      if (BIT_STORE_INSTR) status_nxt[`ST_T_BIT] = BIT_STORE_VAL;
      if (ALU_UPDATE) begin
        if (ALU_FLAG_MASK[4]) status_nxt[`ST_H_BIT] = ALU_FLAGS[4];
        if (ALU_FLAG_MASK[3]) status_nxt[`ST_V_BIT] = ALU_FLAGS[3];
        if (ALU_FLAG_MASK[2]) status_nxt[`ST_N_BIT] = ALU_FLAGS[2];
        if (ALU_FLAG_MASK[1]) status_nxt[`ST_Z_BIT] = ALU_FLAGS[1];
        if (ALU_FLAG_MASK[0]) status_nxt[`ST_C_BIT] = ALU_FLAGS[0];
      end
    end
    status_nxt[`ST_S_BIT] = status_nxt[`ST_N_BIT] ^ status_nxt[`ST_V_BIT];
  end

  // Interrupt entry does not touch the status register.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      status_flags_r <= `STATUS_RESET;
    end else if (CE) begin
      status_flags_r <= status_nxt;
    end
  end

  // Stack pointer with a temporary low byte committed on the high byte write.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      sp_r      <= SRAM_TOP & sp_mask;
      sp_temp_r <= 8'h00;
    end else if (CE) begin
      if (wr_spl) begin
        sp_temp_r <= IO_WDATA;
      end
      if (wr_sph) begin
        sp_r <= {IO_WDATA, sp_temp_r} & sp_mask;
      end else if (SP_LOAD) begin
        sp_r <= SP_NEXT & sp_mask;
      end
    end
  end

  // Reading the low byte latches the high byte for the following read.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      sp_rd_temp_r <= 8'h00;
    end else if (CE && IO_RD && IO_ADDR == `SP_LOW_OFF) begin
      sp_rd_temp_r <= sp_r[15:8];
    end
  end

  // Read data, one wait state when a status write changes the global enable.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      IO_RDATA <= 8'h00;
      wait_r   <= 1'b0;
      IO_WAIT  <= 1'b0;
    end else if (CE) begin
      wait_r  <= ie_change && !wait_r;
      IO_WAIT <= ie_change && !wait_r;
      case (IO_ADDR)
        `GUARD_OFF:   IO_RDATA <= {6'h00, sp_win, io_win};
        `SP_LOW_OFF:  IO_RDATA <= sp_r[7:0];
        `SP_HIGH_OFF: IO_RDATA <= sp_rd_temp_r;
        `STATUS_OFF:  IO_RDATA <= status_flags_r;
        default:      IO_RDATA <= 8'h00;
      endcase
    end
  end

  // Registered outputs toward the CPU.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      INT_ALLOW     <= 1'b0;
      IO_UNLOCKED   <= 1'b0;
      SELF_PROG_OK  <= 1'b0;
      BIT_LOAD_VAL  <= 1'b0;
      STACK_POINTER <= 16'h0000;
      STATUS_FLAGS  <= `STATUS_RESET;
    end else if (CE) begin
      INT_ALLOW     <= INT_PENDING && status_nxt[`ST_IE_BIT] && win_kind == core_regs_pkg::WIN_NONE
                       && !key_io && !key_sp && !sp_block && !wr_spl;
      IO_UNLOCKED   <= io_win;
      SELF_PROG_OK  <= sp_win;
      BIT_LOAD_VAL  <= status_nxt[`ST_T_BIT];
      STACK_POINTER <= sp_r;
      STATUS_FLAGS  <= status_nxt;
    end
  end

  chk_guard_read_bits: assert property (@(posedge CLK) disable iff (!NRST)
    (CE && IO_ADDR == `GUARD_OFF) |=> IO_RDATA[7:2] == 6'h00)
    else $error("Guard upper bits not zero.");

  chk_guard_io_bit: assert property (@(posedge CLK) disable iff (!NRST)
    (CE && IO_ADDR == `GUARD_OFF) |=> IO_RDATA[0] == $past(io_win))
    else $error("Guard bit 0 does not follow the unlock window.");

  chk_no_int_window: assert property (@(posedge CLK) disable iff (!NRST)
    (CE && (io_win || sp_win)) |=> !INT_ALLOW)
    else $error("Interrupt allowed inside a guard window.");

  chk_sign_xor: assert property (@(posedge CLK) disable iff (!NRST)
    status_flags_r[`ST_S_BIT] == (status_flags_r[`ST_N_BIT] ^ status_flags_r[`ST_V_BIT]))
    else $error("Sign bit differs from negative xor overflow.");

  chk_ie_kept: assert property (@(posedge CLK) disable iff (!NRST)
    (CE && INT_TAKEN && !wr_status && !SEI_EXEC && !CLI_EXEC)
      |=> status_flags_r[`ST_IE_BIT] == $past(status_flags_r[`ST_IE_BIT]))
    else $error("Global enable changed by interrupt entry.");

  chk_sp_commit: assert property (@(posedge CLK) disable iff (!NRST)
    (CE && wr_sph) |=> sp_r == ({$past(IO_WDATA), $past(sp_temp_r)} & sp_mask))
    else $error("Stack pointer low byte not committed with high byte.");

  chk_io_abort: assert property (@(posedge CLK) disable iff (!NRST)
    (CE && io_win && !key_io && (DATA_WR || SLEEP_EXEC || NVM_ACCESS)) |=> !io_win)
    else $error("Unlock window not closed by abort event.");

  chk_sp_abort: assert property (@(posedge CLK) disable iff (!NRST)
    (CE && sp_win && !key_sp && (NVM_ACCESS || SLEEP_EXEC)) |=> !sp_win)
    else $error("Self-program window not closed by abort event.");

  chk_wait_state: assert property (@(posedge CLK) disable iff (!NRST)
    (CE && ie_change && !wait_r) |=> IO_WAIT)
    else $error("No wait state on global enable change.");

  chk_guard_sp_bit: assert property (@(posedge CLK) disable iff (!NRST)
    (CE && IO_ADDR == `GUARD_OFF) |=> IO_RDATA[1] == $past(sp_win))
    else $error("Guard bit 1 does not follow the self-program window.");

  chk_sp_read_low: assert property (@(posedge CLK) disable iff (!NRST)
    (CE && IO_ADDR == `SP_LOW_OFF) |=> IO_RDATA == $past(sp_r[7:0]))
    else $error("Stack pointer low byte read wrong.");

  chk_sp_read_high: assert property (@(posedge CLK) disable iff (!NRST)
    (CE && IO_ADDR == `SP_HIGH_OFF) |=> IO_RDATA == $past(sp_rd_temp_r))
    else $error("Stack pointer high byte read wrong.");

  chk_sp_unused_zero: assert property (@(posedge CLK) disable iff (!NRST)
    (sp_r & ~sp_mask) == 16'h0000)
    else $error("Unimplemented stack pointer bits set.");

  chk_sp_out_zero: assert property (@(posedge CLK) disable iff (!NRST)
    (STACK_POINTER & ~sp_mask) == 16'h0000)
    else $error("Unimplemented stack pointer output bits set.");

  chk_sp_hold_low: assert property (@(posedge CLK) disable iff (!NRST)
    (CE && wr_spl && !SP_LOAD) |=> sp_r == $past(sp_r))
    else $error("Stack pointer changed on a low byte write.");

  chk_sp_temp_load: assert property (@(posedge CLK) disable iff (!NRST)
    (CE && wr_spl) |=> sp_temp_r == $past(IO_WDATA))
    else $error("Low byte not held in the temporary register.");

  chk_io_key_open: assert property (@(posedge CLK) disable iff (!NRST)
    (CE && key_io) |=> io_win)
    else $error("Unlock key did not open the window.");

  chk_sp_key_open: assert property (@(posedge CLK) disable iff (!NRST)
    (CE && key_sp) |=> sp_win)
    else $error("Self-program key did not open the window.");

  chk_unlock_out: assert property (@(posedge CLK) disable iff (!NRST)
    CE |=> IO_UNLOCKED == $past(io_win))
    else $error("Unlock output does not follow the window.");

  chk_selfprog_out: assert property (@(posedge CLK) disable iff (!NRST)
    CE |=> SELF_PROG_OK == $past(sp_win))
    else $error("Self-program output does not follow the window.");

  chk_ie_gate: assert property (@(posedge CLK) disable iff (!NRST)
    (CE && !status_nxt[`ST_IE_BIT]) |=> !INT_ALLOW)
    else $error("Interrupt allowed with the global enable clear.");

  chk_int_resume: assert property (@(posedge CLK) disable iff (!NRST)
    (CE && INT_PENDING && status_nxt[`ST_IE_BIT] && !io_win && !sp_win && !sp_block && !IO_WR) |=> INT_ALLOW)
    else $error("Pending interrupt not allowed after the window.");

  chk_sp_block_int: assert property (@(posedge CLK) disable iff (!NRST)
    (CE && sp_block) |=> !INT_ALLOW)
    else $error("Interrupt allowed after a low byte write.");

  chk_sp_block_abort: assert property (@(posedge CLK) disable iff (!NRST)
    (CE && sp_block && IO_WR && !wr_spl) |=> !sp_block)
    else $error("Interrupt block not ended by an I/O write.");

  chk_io_write_abort: assert property (@(posedge CLK) disable iff (!NRST)
    (CE && io_win && IO_WR && !key_io) |=> !io_win)
    else $error("Unlock window not closed by an I/O write.");

  chk_status_write: assert property (@(posedge CLK) disable iff (!NRST)
    (CE && wr_status) |=> status_flags_r[`ST_IE_BIT] == $past(IO_WDATA[`ST_IE_BIT]))
    else $error("Global enable not taken from a status write.");

  chk_sei_set: assert property (@(posedge CLK) disable iff (!NRST)
    (CE && SEI_EXEC && !CLI_EXEC && !wr_status) |=> status_flags_r[`ST_IE_BIT])
    else $error("Set instruction did not raise the global enable.");

  chk_cli_clear: assert property (@(posedge CLK) disable iff (!NRST)
    (CE && CLI_EXEC && !wr_status) |=> !status_flags_r[`ST_IE_BIT])
    else $error("Clear instruction did not drop the global enable.");

  chk_bit_store: assert property (@(posedge CLK) disable iff (!NRST)
    (CE && BIT_STORE_INSTR && !wr_status) |=> status_flags_r[`ST_T_BIT] == $past(BIT_STORE_VAL))
    else $error("Bit store did not reach the copy bit.");

  chk_bit_load: assert property (@(posedge CLK) disable iff (!NRST)
    CE |=> BIT_LOAD_VAL == status_flags_r[`ST_T_BIT])
    else $error("Bit load output differs from the copy bit.");

  chk_carry_update: assert property (@(posedge CLK) disable iff (!NRST)
    (CE && ALU_UPDATE && ALU_FLAG_MASK[0] && !wr_status) |=> status_flags_r[`ST_C_BIT] == $past(ALU_FLAGS[0]))
    else $error("Carry flag not taken from the ALU.");
endmodule
`default_nettype wire

// File: rtl/core_regs_pkg.sv
// Types shared by the core register bank.
package core_regs_pkg;
  typedef enum logic [1:0] {WIN_NONE, WIN_IO, WIN_SELFPROG} window_e;
endpackage

// File: rtl/core_regs_regs.svh
// Register offsets, field positions, keys and reset values of the core register bank.
`ifndef CORE_REGS_REGS_SVH
`define CORE_REGS_REGS_SVH
`define GUARD_OFF        6'h04
`define SP_LOW_OFF       6'h0d
`define SP_HIGH_OFF      6'h0e
`define STATUS_OFF       6'h0f
`define GUARD_RESET      8'h00
`define STATUS_RESET     8'h00
`define SELF_PROGRAM_KEY 8'h9d
`define IO_UNLOCK_KEY    8'hd8
`define GUARD_IO_BIT     0
`define GUARD_SP_BIT     1
`define WINDOW_INSTRS    3'h4
`define ST_IE_BIT        7
`define ST_T_BIT         6
`define ST_H_BIT         5
`define ST_S_BIT         4
`define ST_V_BIT         3
`define ST_N_BIT         2
`define ST_Z_BIT         1
`define ST_C_BIT         0
`endif

// File: rtl/instr_window.sv
// Counts executed instructions for a four-instruction guard window.
`timescale 1ns/10ps
`default_nettype none
`include "core_regs_regs.svh"
module instr_window #(
  parameter int LENGTH = 4
) (
  input  wire logic CLK,
  input  wire logic NRST,
  input  wire logic CE,
  input  wire logic start,
  input  wire logic retire,
  input  wire logic abort,
  output logic      open_o
);
  logic [3:0] count_r;

  if (LENGTH < 1 || LENGTH > 15) begin : g_bad_length
    $error("LENGTH out of range.");
  end

  // The window opens after the start cycle and closes after LENGTH retired instructions.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      open_o  <= 1'b0;
      count_r <= 4'h0;
    end else if (CE) begin
      if (start) begin
        open_o  <= 1'b1;
        count_r <= 4'h0;
      end else if (open_o && abort) begin
        open_o <= 1'b0;
      end else if (open_o && retire) begin
        count_r <= count_r + 4'h1;
        if (count_r + 4'h1 >= 4'(LENGTH)) open_o <= 1'b0;
      end
    end
  end

  chk_close_after_count: assert property (@(posedge CLK) disable iff (!NRST)
    (CE && open_o && !start && !abort && retire && count_r == 4'(LENGTH - 1)) |=> !open_o)
    else $error("Window did not close after its last instruction.");
endmodule
`default_nettype wire

// File: test/tb.sv
// Self-checking bench for the core register bank.
`timescale 1ns/10ps
`default_nettype none
`include "core_regs_regs.svh"
module tb;
  logic        CLK = 1'b0;
  logic        NRST = 1'b0;
  logic        CE = 1'b1;
  logic [5:0]  IO_ADDR = 6'h00;
  logic        IO_WR = 1'b0;
  logic        IO_RD = 1'b0;
  logic [7:0]  IO_WDATA = 8'h00;
  logic [9:0]  pl = 10'h000;
  logic        BIT_STORE_VAL = 1'b0;
  logic        INT_PENDING = 1'b0;
  logic [4:0]  ALU_FLAGS = 5'h00;
  logic [4:0]  ALU_FLAG_MASK = 5'h00;
  logic [15:0] SP_NEXT = 16'h0000;
  logic [7:0]  IO_RDATA;
  logic [7:0]  STATUS_FLAGS;
  logic [15:0] STACK_POINTER;
  logic        IO_WAIT, INT_ALLOW, IO_UNLOCKED, SELF_PROG_OK, BIT_LOAD_VAL;
  int          n_errors = 0;
  int          total_checks = 0;
  int          n_wait = 0;
  int          nw;
  always #2 CLK = ~CLK;
  always @(posedge CLK) if (IO_WAIT === 1'b1) n_wait <= n_wait + 1;
  core_regs #(.SP_BITS(14), .SRAM_TOP(16'h3fff)) core_regs_i (
    .CLK(CLK), .NRST(NRST), .CE(CE), .IO_ADDR(IO_ADDR), .IO_WR(IO_WR), .IO_RD(IO_RD),
    .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .IO_WAIT(IO_WAIT), .DATA_WR(pl[0]),
    .NVM_ACCESS(pl[1]), .SLEEP_EXEC(pl[2]), .INSTR_RETIRE(pl[3]), .INT_TAKEN(pl[4]),
    .SEI_EXEC(pl[5]), .CLI_EXEC(pl[6]), .BIT_STORE_INSTR(pl[7]), .BIT_STORE_VAL(BIT_STORE_VAL),
    .ALU_UPDATE(pl[8]), .ALU_FLAGS(ALU_FLAGS), .ALU_FLAG_MASK(ALU_FLAG_MASK), .SP_LOAD(pl[9]),
    .SP_NEXT(SP_NEXT), .INT_PENDING(INT_PENDING), .INT_ALLOW(INT_ALLOW), .IO_UNLOCKED(IO_UNLOCKED),
    .SELF_PROG_OK(SELF_PROG_OK), .BIT_LOAD_VAL(BIT_LOAD_VAL), .STACK_POINTER(STACK_POINTER),
    .STATUS_FLAGS(STATUS_FLAGS)
  );
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge CLK);
    IO_ADDR <= a;
    IO_WDATA <= d;
    IO_WR <= 1'b1;
    @(posedge CLK);
    IO_WR <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge CLK);
    IO_ADDR <= a;
    IO_RD <= 1'b1;
    @(posedge CLK);
    IO_RD <= 1'b0;
    #1;
    check(IO_RDATA, exp);
  endtask
  task automatic pulse(input int i);
    @(posedge CLK);
    pl[i] <= 1'b1;
    @(posedge CLK);
    pl[i] <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic alu(input logic [4:0] f, input logic [4:0] m, input logic [7:0] exp);
    @(posedge CLK);
    ALU_FLAGS <= f;
    ALU_FLAG_MASK <= m;
    pulse(8);
    idle(2);
    check(STATUS_FLAGS, exp);
  endtask
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #8000;
    n_errors++;
    close_out;
  end
  initial begin
    repeat (4) @(posedge CLK);
    NRST <= 1'b1;
    idle(2);
    check(STACK_POINTER, 16'h3fff);
    check(STATUS_FLAGS, 8'h00);
    rd(`GUARD_OFF, 8'h00);
    rd(`SP_LOW_OFF, 8'hff);
    rd(`SP_HIGH_OFF, 8'h3f);
    INT_PENDING <= 1'b1;
    idle(2);
    check(INT_ALLOW, 1'b0);
    nw = n_wait;
    wr(`STATUS_OFF, 8'h80);
    idle(2);
    check(16'(n_wait - nw), 16'h0001);
    check(INT_ALLOW, 1'b1);
    nw = n_wait;
    wr(`STATUS_OFF, 8'h80);
    idle(2);
    check(16'(n_wait - nw), 16'h0000);
    pulse(4);
    idle(2);
    check(STATUS_FLAGS, 8'h80);
    wr(`GUARD_OFF, `IO_UNLOCK_KEY);
    idle(2);
    check(IO_UNLOCKED, 1'b1);
    check(INT_ALLOW, 1'b0);
    rd(`GUARD_OFF, 8'h01);
    repeat (3) pulse(3);
    rd(`GUARD_OFF, 8'h01);
    pulse(3);
    idle(2);
    rd(`GUARD_OFF, 8'h00);
    check(IO_UNLOCKED, 1'b0);
    check(INT_ALLOW, 1'b1);
    for (int c = 1; c <= 2; c++) begin
      wr(`GUARD_OFF, `SELF_PROGRAM_KEY);
      idle(2);
      check(SELF_PROG_OK, 1'b1);
      rd(`GUARD_OFF, 8'h02);
      pulse(c);
      idle(2);
      rd(`GUARD_OFF, 8'h00);
      check(SELF_PROG_OK, 1'b0);
    end
    for (int c = 0; c <= 3; c++) begin
      wr(`GUARD_OFF, `IO_UNLOCK_KEY);
      if (c == 3) wr(6'h05, 8'h5a);
      else pulse(c);
      idle(2);
      rd(`GUARD_OFF, 8'h00);
    end
    rd(6'h05, 8'h00);
    wr(`GUARD_OFF, 8'hfc);
    rd(`GUARD_OFF, 8'h00);
    wr(`SP_LOW_OFF, 8'h34);
    idle(2);
    check(INT_ALLOW, 1'b0);
    check(STACK_POINTER, 16'h3fff);
    repeat (4) pulse(3);
    idle(2);
    check(INT_ALLOW, 1'b1);
    wr(`SP_LOW_OFF, 8'h34);
    wr(`SP_HIGH_OFF, 8'hff);
    idle(2);
    check(INT_ALLOW, 1'b1);
    check(STACK_POINTER, 16'h3f34);
    rd(`SP_LOW_OFF, 8'h34);
    rd(`SP_HIGH_OFF, 8'h3f);
    SP_NEXT <= 16'hffff;
    pulse(9);
    idle(2);
    check(STACK_POINTER, 16'h3fff);
    pulse(6);
    idle(2);
    check(STATUS_FLAGS, 8'h00);
    check(INT_ALLOW, 1'b0);
    pulse(5);
    BIT_STORE_VAL <= 1'b1;
    pulse(7);
    idle(2);
    check(BIT_LOAD_VAL, 1'b1);
    check(STATUS_FLAGS, 8'hc0);
    alu(5'b01100, 5'h1f, 8'hcc);
    alu(5'b10101, 5'h1f, 8'hf5);
    alu(5'b00010, 5'b00010, 8'hf7);
    wr(`STATUS_OFF, 8'h10);
    rd(`STATUS_OFF, 8'h00);
    CE <= 1'b0;
    pulse(5);
    CE <= 1'b1;
    idle(2);
    check(STATUS_FLAGS, 8'h00);
    close_out;
  end
endmodule
`default_nettype wire
